// ==== dv/acsp_host_model.sv ====
// host serial master model for the configuration port
`timescale 1ns/100ps
module acsp_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_miso,
  output logic            o_sclk,
  output logic            o_csn,
  output logic            o_mosi,
  output logic            o_done,
  output logic [7:0]      o_rdata,
  output logic            o_idle_miso
);
  initial begin
    o_sclk = 1'b0;
    o_csn = 1'b1;
    o_mosi = 1'b0;
    o_done = 1'b0;
    o_rdata = 8'h00;
    o_idle_miso = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // sel low leaves select high so the clocks fall outside any frame
  task automatic send(input logic [15:0] word, input logic sel, input int nbits);
    logic [7:0] rd;
    rd = 8'h00;
    o_csn = ~sel;
    wait_clk(10);
    for (int i = 0; i < nbits; i++) begin
      o_mosi = word[15-i];
      wait_clk(20);
      if (i >= 8) rd = {rd[6:0], i_miso};
      o_sclk = 1'b1;
      wait_clk(20);
      o_sclk = 1'b0;
    end
    wait_clk(20);
    o_csn = 1'b1;
    // released data line shows the inverse, never a held last bit
    o_mosi = ~o_mosi;
    wait_clk(12);
    o_idle_miso = i_miso;
    o_rdata = rd;
    o_done = 1'b1;
    wait_clk(1);
    o_done = 1'b0;
  endtask
endmodule // acsp_host_model

// ==== dv/testbench.sv ====
// self-checking bench for the serial configuration port
`timescale 1ns/100ps
module testbench;
  typedef struct packed {logic [7:0] rd; logic [7:0] ctrl; logic [3:0] ext;} acsp_note_t;
  logic       clk, rstn, cfg_rstn, apos, aneg, sclk, csn, mosi, miso;
  logic       align_int, hold_mode, done, idle_miso;
  logic [3:0] align_ext;
  logic [7:0] ctrl, rdata;
  logic [7:0] regs [4];
  logic [31:0] lfsr;
  acsp_note_t exp_q [$];
  int         bad_count = 0;
  int         num_checks = 0;

  acsp_top acsp_top_i (.i_clk(clk), .i_rstn(rstn), .i_cfg_rstn(cfg_rstn), .i_sclk(sclk),
    .i_csn(csn), .i_mosi(mosi), .i_align_pulse_pos(apos), .i_align_pulse_neg(aneg),
    .o_miso(miso), .o_align_int(align_int), .o_clk_hold_mode(hold_mode),
    .o_align_ext(align_ext), .o_ctrl(ctrl));
  acsp_host_model acsp_host_model_i (.i_clk(clk), .i_miso(miso), .o_sclk(sclk), .o_csn(csn),
    .o_mosi(mosi), .o_done(done), .o_rdata(rdata), .o_idle_miso(idle_miso));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic frame(input logic r, input logic [6:0] a, input logic [7:0] d,
                       input logic sel, input int n);
    acsp_note_t note;
    note.rd = (!sel && n > 8) ? 8'hff : ((r && n == 16 && a < 4) ? regs[a[1:0]] : 8'h00);
    if (!r && sel && n == 16 && a < 4) regs[a[1:0]] = d;
    note.ctrl = regs[0];
    note.ext = regs[1][3:0];
    exp_q.push_back(note);
    acsp_host_model_i.send({r, a, d}, sel, n);
  endtask
  task automatic align(input int n);
    int t;
    frame(1'b0, 7'h01, n[7:0], 1'b1, 16);
    @(posedge clk);
    #1 apos = 1'b1;
    aneg = 1'b0;
    // held well past the minimum width
    repeat (12) @(posedge clk);
    #1 check(align_int, "alignment pulse not raised");
    apos = 1'b0;
    aneg = 1'b1;
    t = 0;
    while (align_int === 1'b1 && t < 40) begin
      @(posedge clk);
      #1 t++;
    end
    check(t >= n + 3 && t <= n + 6, "alignment stretch length");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    acsp_note_t note;
    forever begin
      @(posedge done);
      check(exp_q.size() > 0, "result with no expectation");
      note = exp_q.pop_front();
      check(rdata === note.rd, "read data");
      check(ctrl === note.ctrl && hold_mode === note.ctrl[0], "control setting");
      check(align_ext === note.ext, "stretch setting");
      check(idle_miso === 1'b1, "output idle level");
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    test_done;
  end
  initial begin
    rstn = 1'b0;
    cfg_rstn = 1'b1;
    apos = 1'b0;
    aneg = 1'b1;
    lfsr = 32'h172166d8;
    regs = '{default: 8'h00};
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clk);
    for (int a = 0; a < 5; a++) frame(1'b1, a[6:0], 8'h00, 1'b1, 16);
    for (int a = 0; a < 5; a++) begin
      lfsr = lfsr_next(lfsr);
      frame(1'b0, a[6:0], lfsr[7:0] & ((a == 1) ? 8'h0f : 8'hff), 1'b1, 16);
      frame(1'b1, a[6:0], 8'h00, 1'b1, 16);
    end
    frame(1'b0, 7'h00, 8'h3c, 1'b0, 16);
    frame(1'b0, 7'h00, 8'h3c, 1'b1, 8);
    frame(1'b1, 7'h00, 8'h00, 1'b1, 16);
    frame(1'b0, 7'h00, 8'ha5, 1'b1, 16);
    @(posedge clk);
    #1 cfg_rstn = 1'b0;
    // looked at before any further clock edge
    #1 check(ctrl === 8'h00 && align_ext === 4'h0, "settings not cleared");
    @(posedge clk);
    #1 cfg_rstn = 1'b1;
    regs = '{default: 8'h00};
    frame(1'b1, 7'h02, 8'h00, 1'b1, 16);
    @(posedge clk);
    #1 apos = 1'b1;
    repeat (12) @(posedge clk);
    #1 check(align_int === 1'b0, "both alignment lines high");
    apos = 1'b0;
    align(0);
    align(5);
    align(15);
    check(exp_q.size() == 0, "results missing");
    test_done;
  end
endmodule // testbench

// ==== hw/acsp_pin_sync.sv ====
// three-stage synchroniser with agreement filter for external pins
`timescale 1ns/100ps
module acsp_pin_sync #(
  parameter int           W         = 5,
  parameter logic [W-1:0] RST_LEVEL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_pin,
  acsp_pin_if.src           pins
);
  if (W < 1) begin : g_chk
    $error("acsp_pin_sync: width must be at least one");
  end

  for (genvar g = 0; g < W; g++) begin : g_pin
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic filt_reg;
    logic agree;
    // the first stage only feeds the second
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        s1_reg <= RST_LEVEL[g];
        s2_reg <= RST_LEVEL[g];
        s3_reg <= RST_LEVEL[g];
      end else begin
        s1_reg <= i_pin[g];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
      end
    end
    assign agree = (s2_reg == s3_reg);
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        filt_reg <= RST_LEVEL[g];
      end else if (agree) begin
        filt_reg <= s3_reg;
      end
    end
    assign pins.level[g] = filt_reg;
    assign pins.rise[g]  = agree & s3_reg & ~filt_reg;
  end
endmodule // acsp_pin_sync

// ==== hw/acsp_top.sv ====
// serial configuration port with alignment pulse stretcher
`timescale 1ns/100ps
module acsp_top #(
  parameter int NUM_REGS = acsp_pkg::NUM_REGS
) (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_cfg_rstn,
  input  wire logic       i_sclk,
  input  wire logic       i_csn,
  input  wire logic       i_mosi,
  input  wire logic       i_align_pulse_pos,
  input  wire logic       i_align_pulse_neg,
  output logic            o_miso,
  output logic            o_align_int,
  output logic            o_clk_hold_mode,
  output logic [3:0]      o_align_ext,
  output logic [7:0]      o_ctrl
);
  if (NUM_REGS < 2 || NUM_REGS > (1 << acsp_pkg::ADDR_W)) begin : g_chk
    $error("acsp_top: NUM_REGS must hold control and alignment and fit the address");
  end

  acsp_pin_if #(.W(acsp_pkg::PIN_COUNT)) pin_bus ();

  acsp_pin_sync #(
    .W         (acsp_pkg::PIN_COUNT),
    .RST_LEVEL (acsp_pkg::PIN_RST)
  ) u_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_pin  ({i_align_pulse_neg, i_align_pulse_pos, i_mosi, i_csn, i_sclk}),
    .pins   (pin_bus)
  );

  function automatic logic reg_hit(input logic [6:0] addr);
    reg_hit = (int'(addr) < NUM_REGS);
  endfunction

  function automatic logic [7:0] reg_default(input int idx);
    if (idx == int'(acsp_pkg::CTRL_ADDR)) begin
      reg_default = acsp_pkg::CTRL_RST;
    end else if (idx == int'(acsp_pkg::ALIGN_ADDR)) begin
      reg_default = acsp_pkg::ALIGN_RST;
    end else begin
      reg_default = 8'h00;
    end
  endfunction

  logic              csn_low;
  logic              sclk_rise;
  logic              mosi_bit;
  assign csn_low   = ~pin_bus.level[acsp_pkg::PIN_CSN];
  assign sclk_rise = pin_bus.rise[acsp_pkg::PIN_SCLK];
  assign mosi_bit  = pin_bus.level[acsp_pkg::PIN_MOSI];

  acsp_pkg::acsp_state_t state_reg;
  logic [3:0]        bit_cnt_reg;
  logic [14:0]       shift_reg;
  logic [7:0]        rd_shift_reg;
  logic              miso_reg;
  logic [7:0]        cfg_mem [NUM_REGS];
  logic              edge_ok;
  logic              hdr_done;
  logic              wr_fire;
  logic [6:0]        hdr_addr;
  logic [6:0]        wr_addr;
  logic [7:0]        wr_data;
  logic [7:0]        rd_data;

  // a bit is taken only on a rising serial edge while selected
  assign edge_ok  = (state_reg == acsp_pkg::ACSP_SHIFT) && csn_low && sclk_rise; // [R1] [R2] [R3]
  assign hdr_done = edge_ok && (bit_cnt_reg == 4'(acsp_pkg::HDR_LAST));
  assign hdr_addr = {shift_reg[5:0], mosi_bit};
  assign wr_addr  = shift_reg[13:7];
  assign wr_data  = {shift_reg[6:0], mosi_bit};
  assign wr_fire  = edge_ok && (bit_cnt_reg == 4'(acsp_pkg::FRAME_BITS - 1))
                    && !shift_reg[14]; // [R10]
  assign rd_data  = reg_hit(hdr_addr) ? cfg_mem[int'(hdr_addr)] : 8'h00;

  // a frame cut short by select rising is dropped, nothing is written
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg   <= acsp_pkg::ACSP_IDLE;
      bit_cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        acsp_pkg::ACSP_IDLE: begin
          bit_cnt_reg <= 4'h0;
          if (csn_low) begin
            state_reg <= acsp_pkg::ACSP_SHIFT;
          end
        end
        acsp_pkg::ACSP_SHIFT: begin
          if (!csn_low) begin
            state_reg <= acsp_pkg::ACSP_IDLE;
          end else if (edge_ok) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(acsp_pkg::FRAME_BITS - 1)) begin
              state_reg <= acsp_pkg::ACSP_DONE;
            end
          end
        end
        acsp_pkg::ACSP_DONE: begin
          // extra clocks after a full frame are ignored
          if (!csn_low) begin
            state_reg <= acsp_pkg::ACSP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      shift_reg <= 15'h0000;
    end else if (edge_ok) begin
      shift_reg <= {shift_reg[13:0], mosi_bit}; // [R3] [R10]
    end
  end

  // the output is driven at all times; idle high matches the board pull-up
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      miso_reg     <= 1'b1;
      rd_shift_reg <= 8'h00;
    end else if (state_reg == acsp_pkg::ACSP_IDLE) begin
      miso_reg     <= ~csn_low; // [R5]
      rd_shift_reg <= 8'h00;
    end else if (hdr_done) begin
      miso_reg     <= shift_reg[6] ? rd_data[7] : 1'b0; // [R4]
      rd_shift_reg <= shift_reg[6] ? {rd_data[6:0], 1'b0} : 8'h00;
    end else if (edge_ok && bit_cnt_reg > 4'(acsp_pkg::HDR_LAST)) begin
      miso_reg     <= rd_shift_reg[7]; // [R2] [R4]
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
    end
  end
  assign o_miso = miso_reg;

  // settings clear at once on the configuration reset, no clock needed
  always_ff @(posedge i_clk or negedge i_cfg_rstn) begin
    if (!i_cfg_rstn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_mem[i] <= reg_default(i); // [R6]
      end
    end else if (!i_rstn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_mem[i] <= reg_default(i);
      end
    end else if (wr_fire && reg_hit(wr_addr)) begin
      cfg_mem[int'(wr_addr)] <= wr_data; // [R10]
    end
  end

  assign o_ctrl          = cfg_mem[int'(acsp_pkg::CTRL_ADDR)];
  assign o_clk_hold_mode = o_ctrl[acsp_pkg::HOLD_POS];
  assign o_align_ext     = cfg_mem[int'(acsp_pkg::ALIGN_ADDR)][acsp_pkg::EXT_LSB +: acsp_pkg::EXT_W];

  // alignment input is active high; differential pair must disagree to count
  logic              align_now;
  logic              align_prev_reg;
  logic              align_fall;
  logic [3:0]        ext_cnt_reg;
  logic [3:0]        ext_cnt_next;
  logic              align_int_reg;
  // a pulse narrower than the filter delay may be lost entirely
  assign align_now  = pin_bus.level[acsp_pkg::PIN_APOS]
                      & ~pin_bus.level[acsp_pkg::PIN_ANEG]; // [R7] [R8]
  assign align_fall = align_prev_reg & ~align_now;

  always_comb begin
    if (align_fall) begin
      ext_cnt_next = o_align_ext; // [R9]
    end else if (ext_cnt_reg != 4'h0) begin
      ext_cnt_next = ext_cnt_reg - 4'h1;
    end else begin
      ext_cnt_next = 4'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      align_prev_reg <= 1'b0;
      ext_cnt_reg    <= 4'h0;
      align_int_reg  <= 1'b0;
    end else begin
      align_prev_reg <= align_now;
      ext_cnt_reg    <= ext_cnt_next;
      align_int_reg  <= align_now | (ext_cnt_next != 4'h0); // [R9]
    end
  end
  assign o_align_int = align_int_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  shift_when_sel_a: assert property ($changed(shift_reg) |-> $past(csn_low && sclk_rise)) // [R1] [R3]
    else $error("shift path moved without select and clock edge");
  count_on_rise_a: assert property (edge_ok && bit_cnt_reg != 4'hf
      |=> bit_cnt_reg == $past(bit_cnt_reg) + 4'h1) // [R2]
    else $error("bit count did not advance on rising edge");
  miso_stable_a: assert property (state_reg != acsp_pkg::ACSP_IDLE && !sclk_rise && csn_low
      |=> $stable(o_miso)) // [R4]
    else $error("output bit changed without a serial edge");
  miso_idle_a: assert property (state_reg == acsp_pkg::ACSP_IDLE && !csn_low |=> o_miso) // [R5]
    else $error("output not driven high while deselected");
  cfg_reset_a: assert property (!i_cfg_rstn |-> o_ctrl == acsp_pkg::CTRL_RST
      && o_align_ext == acsp_pkg::ALIGN_RST[3:0]) // [R6]
    else $error("settings not at default under configuration reset");
  ext_load_a: assert property (align_fall |=> ext_cnt_reg == $past(o_align_ext)) // [R9]
    else $error("stretch count not loaded on alignment fall");
  ext_end_a: assert property (ext_cnt_reg == 4'h1 && !align_now && !align_fall
      |=> !o_align_int) // [R9]
    else $error("alignment pulse stretched too long");
  ctrl_write_a: assert property (wr_fire && wr_addr == acsp_pkg::CTRL_ADDR
      |=> o_ctrl == $past(wr_data)) // [R10]
    else $error("control write not stored");

  write_frame_c: cover property (wr_fire);
  // eight more serial bits at the bench rate take about 320 clocks
  read_frame_c: cover property (hdr_done && shift_reg[6] ##[1:400] state_reg == acsp_pkg::ACSP_DONE);
  stretch_c: cover property (align_fall && o_align_ext == 4'hf);
  cfg_reset_c: cover property (!i_cfg_rstn);
endmodule // acsp_top

// ==== pkg/acsp_pin_if.sv ====
// filtered pin levels and rising edges passed from the synchroniser
`timescale 1ns/100ps
interface acsp_pin_if #(parameter int W = 5);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface // acsp_pin_if

// ==== pkg/acsp_pkg.sv ====
// constants shared by the adc serial configuration port
// Notes on behaviour
// R1: serial clock moves bits on the data lines only while select is low.
// R2: data is shifted in and out on the rising serial clock edge.
// R3: input line bits enter the shift path only while select is low.
// R4: readback bits shift out on the output line only while selected.
// R5: output line is always driven, idle high when deselected, never released.
// R6: configuration reset low returns every setting to default without a clock.
// R7: the host drives the alignment input high to realign converters.
// R8: the host holds the alignment pulse at least the minimum width.
// R9: internal alignment pulse is stretched by a programmed 0 to 15 cycles.
// R10: fixed 16-bit frame: read flag, 7-bit address, 8-bit data, msb first.
package acsp_pkg;
  localparam int          FRAME_BITS  = 16;
  localparam int          ADDR_W      = 7;
  localparam int          DATA_W      = 8;
  localparam int          NUM_REGS    = 4;
  localparam int          SYNC_STAGES = 3;
  localparam int          PIN_COUNT   = 5;
  localparam logic [6:0]  CTRL_ADDR   = 7'h00;
  localparam logic [6:0]  ALIGN_ADDR  = 7'h01;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  ALIGN_RST   = 8'h00;
  localparam int          HOLD_POS    = 0;
  localparam int          EXT_LSB     = 0;
  localparam int          EXT_W       = 4;
  localparam int          HDR_LAST    = 7;
  localparam int          PIN_SCLK    = 0;
  localparam int          PIN_CSN     = 1;
  localparam int          PIN_MOSI    = 2;
  localparam int          PIN_APOS    = 3;
  localparam int          PIN_ANEG    = 4;
  // reset levels match the idle pins: select high, negative alignment leg high
  localparam logic [4:0]  PIN_RST     = 5'h12;
  typedef enum logic [1:0] {ACSP_IDLE, ACSP_SHIFT, ACSP_DONE} acsp_state_t;
endpackage
